// [hdl/scr_config_regs.sv]
`timescale 1ns/1ps

// Summary of operation
// - Writing top config bit resets whole chip.
// - Reset trigger self-clears, always reads zero.
// - Direction bit: zero descends, one ascends; default one.
// - Config register resets 0x30; bit4 reads one.
// - Mode field: zero normal, three power down.
module scr_config_regs (
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_sdi_in,
    output logic            spi_sdo_out,
    output logic            spi_sdo_oe_n_out,
    output logic            stream_addr_direction_out,
    output logic [1:0]      op_mode_out,
    output logic            power_down_out,
    output logic            chip_reset_out
);

    logic                   sclk_s;
    logic                   cs_sel_s;
    logic                   sdi_s;
    logic                   sclk_d_ff;
    scr_pkg::scr_state_e    state_ff;
    scr_pkg::scr_state_e    nxt_state;
    logic [3:0]             bit_cnt_ff;
    logic [15:0]            rx_ff;
    logic                   rd_ff;
    logic [14:0]            addr_ff;
    logic [7:0]             tx_ff;
    logic                   sdo_ff;
    logic                   sdo_oe_n_ff;
    logic                   dir_ff;
    logic                   rsvd_hi_ff;
    logic [3:0]             rsvd_lo_ff;
    logic [1:0]             mode_ff;
    logic [5:0]             dev_rsvd_ff;
    logic [3:0]             rst_cnt_ff;
    logic                   chip_rst_ff;
    logic                   pwr_dn_ff;

    // Pins are asynchronous to ref_clk_in, so all three pass the synchroniser together.
    // Chip select travels inverted because the synchroniser clears to zero, which then reads as deselected.
    scr_sync #(
        .WIDTH      (3)
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .d_in       ({spi_sclk_in, ~spi_cs_n_in, spi_sdi_in}),
        .q_out      ({sclk_s, cs_sel_s, sdi_s})
    );

    // Read value of any address; unmapped addresses read zero.
    function automatic logic [7:0] rd_val(input logic [14:0] a, input logic [7:0] cfg_a, input logic [7:0] dev);
        rd_val = (a == scr_pkg::IFACE_CFG_A_OFS) ? cfg_a :
                 (a == scr_pkg::DEV_OP_CFG_OFS)  ? dev   : 8'h00;
    endfunction : rd_val

    // Edge detection, decode and write strobes; no false frame opens as reset is released.
    wire        cs_n_s     = ~cs_sel_s;
    wire        sclk_rise  = sclk_s & ~sclk_d_ff;
    wire        sclk_fall  = ~sclk_s & sclk_d_ff;
    wire        rst_busy   = (rst_cnt_ff != 4'h0);
    wire [15:0] cmd_word   = {rx_ff[14:0], sdi_s};
    wire [7:0]  wr_byte    = {rx_ff[6:0], sdi_s};
    wire        cmd_done   = (state_ff == scr_pkg::ST_CMD) && sclk_rise && !cs_n_s && (bit_cnt_ff == 4'hF);
    wire        byte_done  = (state_ff == scr_pkg::ST_DATA) && sclk_rise && !cs_n_s && (bit_cnt_ff == 4'h7);
    wire        wr_en      = byte_done && !rd_ff;
    wire        wr_cfg_a   = wr_en && (addr_ff == scr_pkg::IFACE_CFG_A_OFS);
    wire        wr_dev     = wr_en && (addr_ff == scr_pkg::DEV_OP_CFG_OFS);
    wire        soft_req   = wr_cfg_a && wr_byte[scr_pkg::SOFT_RST_BIT];
    wire        regs_dflt  = soft_req || rst_busy;
    // Trigger bit always reads zero and bit 4 always reads one.
    wire [7:0]  cfg_a_rd   = {1'b0, rsvd_hi_ff, dir_ff, 1'b1, rsvd_lo_ff};
    wire [7:0]  dev_rd     = {dev_rsvd_ff, mode_ff};
    // Streaming steps the address by the direction bit.
    wire [14:0] addr_step  = dir_ff ? 15'(addr_ff + 15'h0001) : 15'(addr_ff - 15'h0001);
    wire        drive_sdo  = (state_ff == scr_pkg::ST_DATA) && rd_ff && !cs_n_s;

    // Frame sequencing; a soft reset abandons the rest of the frame.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            scr_pkg::ST_IDLE: if (!cs_n_s && !rst_busy) nxt_state = scr_pkg::ST_CMD;
            scr_pkg::ST_CMD:  if (cs_n_s) nxt_state = scr_pkg::ST_IDLE;
                              else if (cmd_done) nxt_state = scr_pkg::ST_DATA;
            scr_pkg::ST_DATA: if (cs_n_s) nxt_state = scr_pkg::ST_IDLE;
                              else if (soft_req) nxt_state = scr_pkg::ST_HOLD;
            scr_pkg::ST_HOLD: if (cs_n_s && !rst_busy) nxt_state = scr_pkg::ST_IDLE;
        endcase
    end

    // State register and serial clock history.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_ff  <= scr_pkg::ST_IDLE;
            sclk_d_ff <= 1'b0;
        end else if (ce_in) begin
            state_ff  <= nxt_state;
            sclk_d_ff <= sclk_s;
        end
    end

    // Bit counter and receive shifter; the counter restarts at every command and byte boundary.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            bit_cnt_ff <= 4'h0;
            rx_ff      <= 16'h0000;
        end else if (ce_in) begin
            if (state_ff == scr_pkg::ST_IDLE || cmd_done || byte_done) begin
                bit_cnt_ff <= 4'h0;
            end else if (sclk_rise) begin
                bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
            end
            if (sclk_rise) begin
                rx_ff <= cmd_word;
            end
        end
    end

    // Address pointer and read direction; the next read byte is fetched as the previous one ends.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rd_ff   <= 1'b0;
            addr_ff <= 15'h0000;
            tx_ff   <= 8'h00;
        end else if (ce_in) begin
            if (cmd_done) begin
                rd_ff   <= cmd_word[15];
                addr_ff <= cmd_word[14:0];
                tx_ff   <= rd_val(cmd_word[14:0], cfg_a_rd, dev_rd);
            end else if (byte_done) begin
                addr_ff <= addr_step;
                tx_ff   <= rd_val(addr_step, cfg_a_rd, dev_rd);
            end else if (sclk_fall && drive_sdo) begin
                tx_ff   <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // Read data changes on the falling serial edge so the host samples it stable on the rising edge.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sdo_ff      <= 1'b0;
            sdo_oe_n_ff <= 1'b1;
        end else if (ce_in) begin
            sdo_oe_n_ff <= !drive_sdo;
            if (sclk_fall && drive_sdo) begin
                sdo_ff <= tx_ff[7];
            end
        end
    end

    // Interface configuration register; held at default while the chip reset runs.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || (ce_in && regs_dflt)) begin
            dir_ff     <= scr_pkg::STREAM_DIR_RST;
            rsvd_hi_ff <= scr_pkg::IFACE_CFG_A_RST[scr_pkg::RSVD_HI_BIT];
            rsvd_lo_ff <= scr_pkg::IFACE_CFG_A_RST[scr_pkg::RSVD_LO_MSB:0];
        end else if (ce_in && wr_cfg_a) begin
            dir_ff     <= wr_byte[scr_pkg::STREAM_DIR_BIT];
            rsvd_hi_ff <= wr_byte[scr_pkg::RSVD_HI_BIT];
            rsvd_lo_ff <= wr_byte[scr_pkg::RSVD_LO_MSB:0];
        end
    end

    // Operating configuration register; codes 1 and 2 are stored but select nothing.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || (ce_in && regs_dflt)) begin
            mode_ff     <= scr_pkg::OP_MODE_RST;
            dev_rsvd_ff <= scr_pkg::DEV_OP_CFG_RST[7:scr_pkg::DEV_RSVD_LSB];
        end else if (ce_in && wr_dev) begin
            mode_ff     <= wr_byte[scr_pkg::OP_MODE_MSB:0];
            dev_rsvd_ff <= wr_byte[7:scr_pkg::DEV_RSVD_LSB];
        end
    end

    // Chip reset timer; the reset pulse is taken from it so the rest of the chip sees a clean level.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rst_cnt_ff  <= 4'h0;
            chip_rst_ff <= 1'b0;
            pwr_dn_ff   <= 1'b0;
        end else if (ce_in) begin
            if (soft_req) begin
                rst_cnt_ff <= scr_pkg::SOFT_RST_CYCLES;
            end else if (rst_busy) begin
                rst_cnt_ff <= 4'(rst_cnt_ff - 4'h1);
            end
            chip_rst_ff <= soft_req || (rst_cnt_ff > 4'h1);
            pwr_dn_ff   <= (mode_ff == scr_pkg::OP_MODE_PWR_DOWN);
        end
    end

    assign spi_sdo_out               = sdo_ff;
    assign spi_sdo_oe_n_out          = sdo_oe_n_ff;
    assign stream_addr_direction_out = dir_ff;
    assign op_mode_out               = mode_ff;
    assign power_down_out            = pwr_dn_ff;
    assign chip_reset_out            = chip_rst_ff;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    sequence soft_trigger_s;
        ce_in && soft_req;
    endsequence

    sequence regs_default_s;
        chip_rst_ff && dir_ff && (mode_ff == scr_pkg::OP_MODE_RST) && (cfg_a_rd == scr_pkg::IFACE_CFG_A_RST);
    endsequence

    soft_reset_dflt_a: assert property (soft_trigger_s |=> regs_default_s)
        else $error("Soft reset did not restore register defaults.");

    trigger_reads_zero_a: assert property (cmd_done && ce_in && cmd_word[15] &&
        (cmd_word[14:0] == scr_pkg::IFACE_CFG_A_OFS) |=> !tx_ff[7])
        else $error("Reset trigger bit read back as one.");

    addr_step_dir_a: assert property (ce_in && byte_done |=>
        addr_ff == ($past(dir_ff) ? 15'($past(addr_ff) + 15'h0001) : 15'($past(addr_ff) - 15'h0001)))
        else $error("Streaming address stepped the wrong way.");

    dir_after_reset_a: assert property ($fell(srst_in) |-> stream_addr_direction_out)
        else $error("Direction bit not ascending after reset.");

    cfg_a_value_a: assert property ($fell(srst_in) |-> cfg_a_rd == scr_pkg::IFACE_CFG_A_RST && cfg_a_rd[4])
        else $error("Configuration register not 0x30 after reset.");

    power_down_map_a: assert property (ce_in && mode_ff == scr_pkg::OP_MODE_PWR_DOWN |=> power_down_out)
        else $error("Mode three did not assert power down.");

    reset_ignore_a: assert property (soft_trigger_s ##1 ce_in |->
        (state_ff == scr_pkg::ST_HOLD) ##1 (rst_busy == 1'b0) && !chip_rst_ff)
        else $error("Serial engine not holding or reset not ending in time.");

endmodule : scr_config_regs

// [hdl/scr_pkg.sv]
package scr_pkg;

    // Serial frame layout: one direction bit, then a register address, then data bytes.
    localparam int          ADDR_W           = 15;
    localparam int          CMD_BITS         = 16;
    localparam int          DATA_BITS        = 8;

    // Register offsets.
    localparam logic [14:0] IFACE_CFG_A_OFS  = 15'h0000;
    localparam logic [14:0] DEV_OP_CFG_OFS   = 15'h0002;

    // Reset values.
    localparam logic [7:0]  IFACE_CFG_A_RST  = 8'h30;
    localparam logic [7:0]  DEV_OP_CFG_RST   = 8'h00;
    localparam logic        STREAM_DIR_RST   = 1'h1;
    localparam logic [1:0]  OP_MODE_RST      = 2'h0;

    // Field positions in the interface configuration register.
    localparam int          SOFT_RST_BIT     = 7;
    localparam int          RSVD_HI_BIT      = 6;
    localparam int          STREAM_DIR_BIT   = 5;
    localparam int          RSVD_ONE_BIT     = 4;
    localparam int          RSVD_LO_MSB      = 3;

    // Field positions and codes in the operating configuration register.
    localparam int          OP_MODE_MSB      = 1;
    localparam int          DEV_RSVD_LSB     = 2;
    localparam logic [1:0]  OP_MODE_NORMAL   = 2'h0;
    localparam logic [1:0]  OP_MODE_PWR_DOWN = 2'h3;

    // Internal chip reset duration, longest time rounded down, never below one cycle.
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam int          SOFT_RST_TIME_NS = 5;
    localparam int          SOFT_RST_RAW     = (SOFT_RST_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0]  SOFT_RST_CYCLES  = (SOFT_RST_RAW < 1) ? 4'h1 : 4'(SOFT_RST_RAW);

    // Serial engine states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD  = 2'b01,
        ST_DATA = 2'b10,
        ST_HOLD = 2'b11
    } scr_state_e;

endpackage : scr_pkg

// [hdl/scr_sync.sv]
`timescale 1ns/1ps

// Two-stage synchroniser for pins from outside the clock domain.
module scr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             srst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // The first stage feeds only the second stage, giving metastability a full cycle to settle.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else if (ce_in) begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end

    assign q_out = q_ff;

endmodule : scr_sync

// [tb/scr_host_model.sv]
`timescale 1ns/1ps

// Serial host: mode 0, MSB first, clock parked low between frames.
module scr_host_model (
    input  wire logic ref_clk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_n_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out
);
    // Half period well above the two reference clocks the synchroniser needs.
    localparam int HALF = 6;

    // An undriven data line reads inverted, so a read outside the data phase cannot pass.
    wire logic sdo_line = sdo_oe_n_in ? ~sdo_in : sdo_in;

    // Idle levels at time zero.
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    // One whole frame; read bits are taken just before each rising clock.
    task automatic xfer(input logic rd, input logic [14:0] a, input int n, input logic [31:0] wd,
                        output logic [31:0] rq);
        logic [47:0] v;
        v  = {rd, a, wd};
        rq = 32'h0;
        @(posedge ref_clk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++) begin
            @(posedge ref_clk_in);
            sdi_out <= v[47-i];
            repeat (HALF) @(posedge ref_clk_in);
            if (i >= 16) rq = {rq[30:0], sdo_line};
            sclk_out <= 1'b1;
            repeat (HALF) @(posedge ref_clk_in);
            sclk_out <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        sdi_out  <= ~sdi_out;
        repeat (8) @(posedge ref_clk_in);
    endtask : xfer
endmodule : scr_host_model

// [tb/tb.sv]
`timescale 1ns/1ps

module tb;
    logic        ref_clk_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic        ce_in      = 1'b1;
    logic        sclk, cs_n, sdi, sdo, sdo_oe_n, dir, pd, crst;
    logic [1:0]  mode;
    logic [31:0] rq;
    int          failures   = 0;
    int          n_tests    = 0;
    int          cyc        = 0;
    int          crst_cnt   = 0;
    int          m_a        = 8'h30;
    int          m_d        = 8'h00;

    scr_host_model i_scr_host_model (.ref_clk_in(ref_clk_in), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n),
        .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));

    scr_config_regs i_scr_config_regs (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(ce_in),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
        .spi_sdo_oe_n_out(sdo_oe_n), .stream_addr_direction_out(dir), .op_mode_out(mode),
        .power_down_out(pd), .chip_reset_out(crst));

    initial begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    task automatic test_done();
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Reference model: bit 7 always reads zero and bit 4 always reads one.
    function automatic int exp_rd(input int a);
        if (a == 0) return (m_a & 8'h6F) | 8'h10;
        if (a == 2) return m_d;
        return 0;
    endfunction : exp_rd

    task automatic wr(input int a, input int n, input logic [31:0] d);
        int s;
        int ad;
        s = ((m_a >> 5) & 1) ? 1 : -1;
        i_scr_host_model.xfer(1'b0, 15'(a), n, d, rq);
        for (int k = 0; k < n; k++) begin
            ad = (a + s * k) & 32'h7FFF;
            if (ad == 0) m_a = (d >> (24 - 8 * k)) & 8'hFF;
            if (ad == 2) m_d = (d >> (24 - 8 * k)) & 8'hFF;
        end
    endtask : wr

    task automatic rd(input int a, input int n);
        int s;
        int e;
        s = ((m_a >> 5) & 1) ? 1 : -1;
        e = 0;
        i_scr_host_model.xfer(1'b1, 15'(a), n, 32'h0, rq);
        for (int k = 0; k < n; k++) e = (e << 8) | exp_rd((a + s * k) & 32'h7FFF);
        chk("read data", e, rq);
    endtask : rd

    // Cycle limit well above the roughly 7700 cycles the sequence needs.
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (crst === 1'b1) crst_cnt <= crst_cnt + 1;
        if (cyc == 50000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h935CA5AF));
        repeat (3) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        rd(0, 1);
        chk("direction", 1, dir);
        chk("mode", 0, mode);
        for (int v = 0; v < 4; v++) begin
            wr(2, 1, {(8'($urandom) & 8'hFC) | 8'(v), 24'h0});
            chk("mode", v, mode);
            chk("power down", v == 3, pd);
            rd(2, 1);
        end
        // Soft reset in a stream whose later byte would restore power down if not ignored.
        crst_cnt = 0;
        i_scr_host_model.xfer(1'b0, 15'h0, 3, 32'h8000_0300, rq);
        m_a = 8'h30;
        m_d = 8'h00;
        chk("chip reset cycles", scr_pkg::SOFT_RST_CYCLES, crst_cnt);
        chk("mode", 0, mode);
        chk("direction", 1, dir);
        rd(0, 1);
        rd(2, 1);
        wr(0, 1, {(8'($urandom) & 8'h7F) | 8'h20, 24'h0});
        rd(0, 1);
        wr(0, 3, {8'h20, 8'($urandom), 8'h01, 8'h00});
        rd(0, 3);
        wr(0, 1, 32'h0);
        chk("direction", 0, dir);
        rd(2, 3);
        // Pin reset in mid-run returns every field to its default.
        wr(2, 1, 32'h0300_0000);
        // Clock enable low freezes every flop, so a whole frame sent meanwhile is lost.
        ce_in <= 1'b0;
        i_scr_host_model.xfer(1'b0, 15'h2, 1, 32'h0, rq);
        chk("mode frozen", 3, mode);
        chk("power down frozen", 1, pd);
        ce_in <= 1'b1;
        srst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        m_a = 8'h30;
        m_d = 8'h00;
        repeat (4) @(posedge ref_clk_in);
        chk("mode", 0, mode);
        chk("power down", 0, pd);
        chk("direction", 1, dir);
        rd(0, 1);
        test_done();
    end
endmodule : tb
